//--- src/mpim_consts.svh
`ifndef MPIM_CONSTS_SVH
`define MPIM_CONSTS_SVH
// modbus function codes
`define MPIM_FC_RD_HOLD   8'h03
`define MPIM_FC_RD_INPUT  8'h04
`define MPIM_FC_WR_SINGLE 8'h06
`define MPIM_FC_WR_MULTI  8'h10
`define MPIM_FC_RD_WR     8'h17
`define MPIM_FC_OBJ       8'h2b
// exception codes
`define MPIM_EX_NONE      8'h00
`define MPIM_EX_FUNC      8'h01
`define MPIM_EX_ADDR      8'h02
`define MPIM_EX_VALUE     8'h03
`define MPIM_EX_FAIL      8'h04
// register windows
`define MPIM_UP_OUT_BASE  16'h07d0
`define MPIM_UP_IN_BASE   16'h0bb8
`define MPIM_TX_BASE      16'h1388
`define MPIM_RX_BASE      16'h1770
// object indices reached by function 2b
`define MPIM_RX_MAP_OBJ   16'h3502
`define MPIM_TX_MAP_OBJ   16'h3602
`define MPIM_CTRL_OBJ     16'h2300
`define MPIM_ERR_OBJ      16'h2302
// filler object index range
`define MPIM_FILL_FIRST   16'h0002
`define MPIM_FILL_LAST    16'h0007
// sizes and reset values
`define MPIM_MAP_MAX      16
`define MPIM_ARR_WORDS    32
`define MPIM_MAX_FIELD    8'h20
`define MPIM_CTRL_RST     8'h01
`endif

//--- src/mpim_layout.sv
`default_nettype none
// bit offset of each mapped entry and total image length
module mpim_layout #(
	parameter int ENTRIES = 16,
	parameter int OW      = 10
) (
	input  wire logic [ENTRIES*8-1:0]         len_i,
	input  wire logic [$clog2(ENTRIES+1)-1:0] count_i,
	output logic      [ENTRIES*OW-1:0]        off_o,
	output logic      [OW-1:0]                total_o
);
	if (OW < $clog2(ENTRIES*32+1)) begin : g_chk
		$error("mpim_layout: offset width too small");
	end

	// running sum over active entries only, packed with no gaps
	always_comb begin
		logic [OW-1:0] acc;
		acc = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			off_o[i*OW +: OW] = acc;
			if (i < int'(count_i)) begin
				acc = acc + OW'(len_i[i*8 +: 8]);
			end
		end
		total_o = acc;
	end
endmodule : mpim_layout
`default_nettype wire

//--- src/mpim_mapper.sv
`include "mpim_consts.svh"
`default_nettype none
module mpim_mapper #(
	parameter int MAP_ENTRIES = `MPIM_MAP_MAX,
	parameter int ARR_WORDS   = `MPIM_ARR_WORDS
) (
	input  wire logic                           mclk_i,
	input  wire logic                           rst_n_i,
	input  wire logic                           req_i,
	input  wire logic [7:0]                     req_func_i,
	input  wire logic [15:0]                    req_addr_i,
	input  wire logic [15:0]                    req_qty_i,
	input  wire logic [15:0]                    req_beat_i,
	input  wire logic                           req_wr_i,
	input  wire logic [7:0]                     req_sub_i,
	input  wire logic [31:0]                    req_wdata_i,
	output logic                                rsp_valid_o,
	output logic [7:0]                          rsp_exc_o,
	output logic [31:0]                         rsp_rdata_o,
	input  wire logic [$clog2(MAP_ENTRIES)-1:0] rx_sel_i,
	output logic [31:0]                         rx_val_o,
	input  wire logic                           tx_we_i,
	input  wire logic [$clog2(MAP_ENTRIES)-1:0] tx_sel_i,
	input  wire logic [31:0]                    tx_val_i,
	input  wire logic [$clog2(ARR_WORDS)-1:0]   upi_sel_i,
	output logic [31:0]                         upi_val_o,
	input  wire logic                           upo_we_i,
	input  wire logic [$clog2(ARR_WORDS)-1:0]   upo_sel_i,
	input  wire logic [31:0]                    upo_val_i,
	input  wire logic                           prog_loaded_i,
	input  wire logic                           prog_fault_i,
	input  wire logic [7:0]                     prog_fault_code_i,
	output mpim_pkg::mpim_prog_type             prog_state_o,
	output logic                                prog_run_o,
	output logic [7:0]                          prog_err_o
);
	import mpim_pkg::*;

	localparam int IMG_BITS = MAP_ENTRIES * 32;
	localparam int OW       = $clog2(IMG_BITS + 1);
	localparam int CW       = $clog2(MAP_ENTRIES + 1);
	localparam int IW       = $clog2(IMG_BITS / 16);
	localparam int AW       = $clog2(ARR_WORDS);
	localparam logic [16:0] IMG_REGS = 17'(IMG_BITS / 16);
	localparam logic [16:0] ARR_REGS = 17'(ARR_WORDS * 2);

	if (MAP_ENTRIES < 2 || MAP_ENTRIES > `MPIM_MAP_MAX || ARR_WORDS < 2 || ARR_WORDS > 500) begin : g_chk
		$error("mpim_mapper: unsupported table or array size");
	end

	logic [31:0]             rx_map_r [MAP_ENTRIES];
	logic [31:0]             tx_map_r [MAP_ENTRIES];
	logic [CW-1:0]           rx_cnt_r, tx_cnt_r;
	logic [IMG_BITS-1:0]     rx_img_r, tx_img_r;
	logic [31:0]             upi_mem [ARR_WORDS];
	logic [31:0]             upo_mem [ARR_WORDS];
	logic [15:0]             hold_r;
	logic [7:0]              ctrl_r;
	logic [MAP_ENTRIES*8-1:0]  rx_len, tx_len;
	logic [MAP_ENTRIES*OW-1:0] rx_off, tx_off;
	logic [OW-1:0]           rx_total, tx_total;
	mpim_region_type         rg;
	logic [15:0]             base, rel, brel;
	logic [16:0]             lim, qty_eff;
	logic                    rd, wr, go, obj_map, obj_tx;
	logic [7:0]              exc;
	logic [31:0]             rdata;

	// true when address a falls inside [b, b+span)
	function automatic logic in_win(input logic [15:0] a, input logic [15:0] b,
			input logic [16:0] span);
		return ({1'b0, a} >= {1'b0, b}) && ({1'b0, a} < ({1'b0, b} + span));
	endfunction : in_win

	function automatic logic is_filler(input logic [31:0] e);
		return (e[31:16] >= `MPIM_FILL_FIRST) && (e[31:16] <= `MPIM_FILL_LAST);
	endfunction : is_filler

	// low byte is the field length
	for (genvar i = 0; i < MAP_ENTRIES; i++) begin : g_len
		assign rx_len[i*8 +: 8] = rx_map_r[i][7:0];
		assign tx_len[i*8 +: 8] = tx_map_r[i][7:0];
	end

	mpim_layout #(.ENTRIES(MAP_ENTRIES), .OW(OW)) u_rx_layout (
		.len_i   (rx_len),
		.count_i (rx_cnt_r),
		.off_o   (rx_off),
		.total_o (rx_total)
	);
	mpim_layout #(.ENTRIES(MAP_ENTRIES), .OW(OW)) u_tx_layout (
		.len_i   (tx_len),
		.count_i (tx_cnt_r),
		.off_o   (tx_off),
		.total_o (tx_total)
	);

	// request decode, window and exception check
	always_comb begin
		logic [31:0] w;
		w       = 32'h0;
		rd      = (req_func_i == `MPIM_FC_RD_HOLD) || (req_func_i == `MPIM_FC_RD_INPUT) ||
		          (req_func_i == `MPIM_FC_RD_WR && !req_wr_i);
		wr      = (req_func_i == `MPIM_FC_WR_SINGLE) || (req_func_i == `MPIM_FC_WR_MULTI) ||
		          (req_func_i == `MPIM_FC_RD_WR && req_wr_i);
		qty_eff = (req_func_i == `MPIM_FC_WR_SINGLE) ? 17'h1 : {1'b0, req_qty_i};
		rg      = RG_NONE;
		base    = 16'h0;
		lim     = 17'h0;
		if (in_win(req_addr_i, `MPIM_UP_OUT_BASE, ARR_REGS)) begin
			rg   = RG_UPO;
			base = `MPIM_UP_OUT_BASE;
			lim  = ARR_REGS;
		end else if (in_win(req_addr_i, `MPIM_UP_IN_BASE, ARR_REGS)) begin
			rg   = RG_UPI;
			base = `MPIM_UP_IN_BASE;
			lim  = ARR_REGS;
		end else if (in_win(req_addr_i, `MPIM_TX_BASE, IMG_REGS)) begin
			rg   = RG_TX;
			base = `MPIM_TX_BASE;
			lim  = 17'((tx_total + 15) >> 4);
		end else if (in_win(req_addr_i, `MPIM_RX_BASE, IMG_REGS)) begin
			rg   = RG_RX;
			base = `MPIM_RX_BASE;
			lim  = 17'((rx_total + 15) >> 4);
		end
		rel     = req_addr_i - base;
		brel    = rel + req_beat_i;
		obj_map = (req_addr_i == `MPIM_RX_MAP_OBJ) || (req_addr_i == `MPIM_TX_MAP_OBJ);
		obj_tx  = (req_addr_i == `MPIM_TX_MAP_OBJ);
		exc     = `MPIM_EX_NONE;
		rdata   = 32'h0;
		if (req_func_i == `MPIM_FC_OBJ) begin
			if (obj_map && req_sub_i == 8'h0) begin
				rdata = 32'(obj_tx ? tx_cnt_r : rx_cnt_r);
				if (req_wr_i && req_wdata_i > 32'(MAP_ENTRIES)) begin
					exc = `MPIM_EX_VALUE;
				end
			end else if (obj_map && req_sub_i <= 8'(MAP_ENTRIES)) begin
				rdata = obj_tx ? tx_map_r[req_sub_i[3:0] - 4'h1] : rx_map_r[req_sub_i[3:0] - 4'h1];
				// entry edits need a deactivated table
				if (req_wr_i && (obj_tx ? tx_cnt_r : rx_cnt_r) != '0) begin
					exc = `MPIM_EX_VALUE;
				end else if (req_wr_i && (req_wdata_i[7:0] == 8'h0 ||
						req_wdata_i[7:0] > `MPIM_MAX_FIELD)) begin
					exc = `MPIM_EX_VALUE;
				end
			end else if (req_addr_i == `MPIM_CTRL_OBJ && req_sub_i == 8'h0) begin
				rdata = {24'h0, ctrl_r};
			end else if (req_addr_i == `MPIM_ERR_OBJ && req_sub_i == 8'h0 && !req_wr_i) begin
				rdata = {24'h0, prog_err_o};
			end else begin
				exc = `MPIM_EX_ADDR;
			end
		end else if (!(rd || wr)) begin
			exc = `MPIM_EX_FUNC;
		end else if (rg == RG_NONE) begin
			exc = `MPIM_EX_ADDR;
		end else if ((rg == RG_UPO || rg == RG_UPI) && req_func_i == `MPIM_FC_WR_SINGLE) begin
			exc = `MPIM_EX_FUNC;
		end else if (qty_eff == 17'h0) begin
			exc = `MPIM_EX_VALUE;
		end else if ({1'b0, rel} + qty_eff > lim) begin
			exc = `MPIM_EX_ADDR;
		end else if ((rg == RG_UPO && wr) || (rg == RG_UPI && rd) ||
				(rg == RG_TX && wr) || (rg == RG_RX && rd)) begin
			exc = `MPIM_EX_ADDR;
		// word aligned start, whole words written
		end else if ((rg == RG_UPO || rg == RG_UPI) && rel[0]) begin
			exc = `MPIM_EX_ADDR;
		end else if (rg == RG_UPI && req_qty_i[0]) begin
			exc = `MPIM_EX_VALUE;
		end else if (rg == RG_TX) begin
			rdata = {16'h0, tx_img_r[{brel[IW-1:0], 4'h0} +: 16]};
		end else if (rg == RG_UPO) begin
			w     = upo_mem[brel[AW:1]];
			rdata = {16'h0, brel[0] ? w[15:0] : w[31:16]};
		end
	end

	assign go = req_i && (exc == `MPIM_EX_NONE);

	// answer one cycle after each request beat
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rsp_valid_o <= 1'b0;
			rsp_exc_o   <= `MPIM_EX_NONE;
			rsp_rdata_o <= 32'h0;
		end else begin
			rsp_valid_o <= req_i;
			rsp_exc_o   <= req_i ? exc : `MPIM_EX_NONE;
			rsp_rdata_o <= go ? rdata : 32'h0;
		end
	end

	// mapping tables and counts, count in sub zero
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rx_cnt_r <= '0;
			tx_cnt_r <= '0;
			for (int i = 0; i < MAP_ENTRIES; i++) begin
				rx_map_r[i] <= 32'h0;
				tx_map_r[i] <= 32'h0;
			end
		end else if (go && req_func_i == `MPIM_FC_OBJ && req_wr_i && obj_map) begin
			if (req_sub_i == 8'h0 && obj_tx) begin
				tx_cnt_r <= req_wdata_i[CW-1:0];
			end else if (req_sub_i == 8'h0) begin
				rx_cnt_r <= req_wdata_i[CW-1:0];
			end else if (obj_tx) begin
				tx_map_r[req_sub_i[3:0] - 4'h1] <= req_wdata_i;
			end else begin
				rx_map_r[req_sub_i[3:0] - 4'h1] <= req_wdata_i;
			end
		end
	end

	// receive image written by the master one register at a time
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rx_img_r <= '0;
		end else if (go && rg == RG_RX && wr) begin
			rx_img_r[{brel[IW-1:0], 4'h0} +: 16] <= req_wdata_i[15:0];
		end
	end

	// filler bits stay zero, image cleared on remap
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tx_img_r <= '0;
		end else if (go && req_func_i == `MPIM_FC_OBJ && req_wr_i && obj_tx && req_sub_i == 8'h0) begin
			tx_img_r <= '0;
		end else if (tx_we_i && int'(tx_sel_i) < int'(tx_cnt_r) && !is_filler(tx_map_r[tx_sel_i])) begin
			for (int b = 0; b < 32; b++) begin
				if (b < int'(tx_map_r[tx_sel_i][7:0]) &&
						int'(tx_off[tx_sel_i*OW +: OW]) + b < IMG_BITS) begin
					tx_img_r[int'(tx_off[tx_sel_i*OW +: OW]) + b] <= tx_val_i[b];
				end
			end
		end
	end

	// received filler value reads as zero
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rx_val_o <= 32'h0;
		end else begin
			rx_val_o <= 32'h0;
			if (int'(rx_sel_i) < int'(rx_cnt_r) && !is_filler(rx_map_r[rx_sel_i])) begin
				for (int b = 0; b < 32; b++) begin
					if (b < int'(rx_map_r[rx_sel_i][7:0]) &&
							int'(rx_off[rx_sel_i*OW +: OW]) + b < IMG_BITS) begin
						rx_val_o[b] <= rx_img_r[int'(rx_off[rx_sel_i*OW +: OW]) + b];
					end
				end
			end
		end
	end

	// input array, high half held until low half commits
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			hold_r <= 16'h0;
		end else if (go && rg == RG_UPI && wr) begin
			if (!brel[0]) begin
				hold_r <= req_wdata_i[15:0];
			end else begin
				upi_mem[brel[AW:1]] <= {hold_r, req_wdata_i[15:0]};
			end
		end
	end

	// program side of both arrays
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			upi_val_o <= 32'h0;
		end else begin
			upi_val_o <= upi_mem[upi_sel_i];
			if (upo_we_i) begin
				upo_mem[upo_sel_i] <= upo_val_i;
			end
		end
	end

	// control bit 0 enables run, survives until cleared
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= `MPIM_CTRL_RST;
		end else if (go && req_func_i == `MPIM_FC_OBJ && req_wr_i && req_addr_i == `MPIM_CTRL_OBJ) begin
			ctrl_r <= req_wdata_i[7:0];
		end
	end

	// runtime state, fault stops program and keeps code
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			prog_state_o <= PS_STOP;
			prog_run_o   <= 1'b0;
			prog_err_o   <= 8'h0;
		end else begin
			unique case (prog_state_o)
				PS_STOP: begin
					if (ctrl_r[0] && prog_loaded_i) begin
						prog_state_o <= PS_RUN;
						prog_run_o   <= 1'b1;
						prog_err_o   <= 8'h0;
					end
				end
				PS_RUN: begin
					if (prog_fault_i) begin
						prog_state_o <= PS_FAULT;
						prog_run_o   <= 1'b0;
						prog_err_o   <= prog_fault_code_i;
					end else if (!ctrl_r[0] || !prog_loaded_i) begin
						prog_state_o <= PS_STOP;
						prog_run_o   <= 1'b0;
					end
				end
				PS_FAULT: begin
					if (!ctrl_r[0]) begin
						prog_state_o <= PS_STOP;
					end
				end
			endcase
		end
	end
endmodule : mpim_mapper
`default_nettype wire

//--- src/mpim_pkg.sv
`default_nettype none
package mpim_pkg;
	// register window hit by a request
	typedef enum logic [2:0] {RG_NONE, RG_UPO, RG_UPI, RG_TX, RG_RX} mpim_region_type;
	// user program runtime state
	typedef enum logic [1:0] {PS_STOP, PS_RUN, PS_FAULT} mpim_prog_type;
endpackage : mpim_pkg
`default_nettype wire

//--- tb/mpim_chk_asserts.sv
`default_nettype none
// watches the request port and program state of the mapper
module mpim_chk (
	input wire logic                    mclk_i,
	input wire logic                    rst_n_i,
	input wire logic                    req_i,
	input wire logic [7:0]              req_func_i,
	input wire logic [15:0]             req_addr_i,
	input wire logic [15:0]             req_qty_i,
	input wire logic                    rsp_valid_o,
	input wire logic [7:0]              rsp_exc_o,
	input wire logic [31:0]             rsp_rdata_o,
	input wire logic                    prog_fault_i,
	input wire logic [7:0]              prog_fault_code_i,
	input wire mpim_pkg::mpim_prog_type prog_state_o,
	input wire logic                    prog_run_o,
	input wire logic [7:0]              prog_err_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import mpim_pkg::*;
	logic fc_ok;
	// function codes the register port knows
	assign fc_ok = req_func_i inside {8'h03, 8'h04, 8'h06, 8'h10, 8'h17, 8'h2b};
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// one request shape gives one exception code
	property ex(f, a, q, x);
		req_i && req_func_i == f && req_addr_i == a && req_qty_i == q |=> rsp_exc_o == x;
	endproperty
	AST_RSP_NEXT: assert property (req_i |=> rsp_valid_o)
		else $error("request not answered");
	AST_RSP_ONLY: assert property (!req_i |=> !rsp_valid_o && rsp_exc_o == 8'h00)
		else $error("answer without request");
	AST_FUNC: assert property (req_i && !fc_ok |=> rsp_exc_o == 8'h01)
		else $error("unknown function not refused");
	AST_EXC_DATA: assert property (rsp_valid_o && rsp_exc_o != 8'h00 |-> !rsp_rdata_o)
		else $error("data on refused beat");
	AST_TX_WR: assert property (ex(8'h10, 16'h1388, 16'h0001, 8'h02))
		else $error("transmit image write accepted");
	AST_UPO_WR: assert property (ex(8'h10, 16'h07d0, 16'h0002, 8'h02))
		else $error("output array write accepted");
	AST_UPI_RD: assert property (ex(8'h03, 16'h0bb8, 16'h0002, 8'h02))
		else $error("input array read accepted");
	AST_ODD: assert property (ex(8'h03, 16'h07d1, 16'h0002, 8'h02))
		else $error("odd array start accepted");
	AST_FAULT: assert property (prog_state_o == PS_RUN && prog_fault_i |=>
		prog_state_o == PS_FAULT && prog_err_o == $past(prog_fault_code_i))
		else $error("fault not recorded");
	AST_RUN: assert property (prog_run_o == (prog_state_o == PS_RUN))
		else $error("run flag disagrees with state");
	// main scenarios reached
	cover property (rsp_valid_o && rsp_exc_o == 8'h00);
	cover property ($rose(prog_run_o));
	cover property (prog_state_o == PS_FAULT);
endmodule : mpim_chk
`default_nettype wire

//--- tb/mpim_master.sv
`default_nettype none
// fieldbus master model: one register beat per call
module mpim_master (
	input  wire logic        mclk_i,
	input  wire logic        rsp_valid_i,
	input  wire logic [7:0]  rsp_exc_i,
	input  wire logic [31:0] rsp_rdata_i,
	output logic             req_o,
	output logic [7:0]       func_o,
	output logic [15:0]      addr_o,
	output logic [15:0]      qty_o,
	output logic [15:0]      beat_o,
	output logic             wr_o,
	output logic [7:0]       sub_o,
	output logic [31:0]      wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		{req_o, func_o, addr_o, qty_o, beat_o, wr_o, sub_o, wdata_o} = '0;
	end
	// drive a beat, take the answer one cycle on; 8'hff marks no answer
	task automatic beat(input logic [7:0] f, input logic [15:0] a, q, b, input logic w,
		input logic [7:0] s, input logic [31:0] d, output logic [7:0] e, output logic [31:0] r);
		@(posedge mclk_i);
		req_o   <= 1'b1;
		func_o  <= f;
		addr_o  <= a;
		qty_o   <= q;
		beat_o  <= b;
		wr_o    <= w;
		sub_o   <= s;
		wdata_o <= d;
		@(posedge mclk_i);
		req_o   <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
		#1;
		e = rsp_valid_i ? rsp_exc_i : 8'hff;
		r = rsp_rdata_i;
	endtask : beat
	task automatic map(input logic [15:0] obj, input logic [3:0] n, input logic [127:0] ent);
		logic [7:0]  e;
		logic [31:0] r;
		beat(8'h2b, obj, 16'h0, 16'h0, 1'b1, 8'h0, 32'h0, e, r);
		for (int i = 0; i < n; i++) begin
			beat(8'h2b, obj, 16'h0, 16'h0, 1'b1, 8'(i + 1), ent[32*i +: 32], e, r);
		end
		beat(8'h2b, obj, 16'h0, 16'h0, 1'b1, 8'h0, {28'h0, n}, e, r);
	endtask : map
endmodule : mpim_master
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mpim_pkg::*;
	typedef struct packed {
		logic [7:0]  f;
		logic [15:0] a;
		logic [7:0]  q, b;
		logic        w;
		logic [7:0]  s;
		logic [31:0] d;
		logic [7:0]  e;
		logic [31:0] r;
	} mpim_row_type;
	logic          mclk = 1'b0, rst_n = 1'b0, tx_we = 1'b0, upo_we = 1'b0;
	logic          fault = 1'b0, loaded = 1'b1, req, wr, rsp_valid, run;
	logic [7:0]    func, sub, rsp_exc, err, e, code = 8'h0;
	logic [15:0]   addr, qty, beat;
	logic [31:0]   wdata, rsp_rdata, rx_val, upi_val, r, tx_val = 32'h0, upo_val = 32'h0;
	logic [3:0]    rx_sel = 4'h0, tx_sel = 4'h0;
	logic [4:0]    upi_sel = 5'h0, upo_sel = 5'h0;
	mpim_prog_type state;
	int            failures = 0, total_checks = 0;
	logic [31:0]   tv[4] = '{32'h1234, 32'hff, 32'hab, 32'hdeadbeef};
	// request, expected exception, expected read data
	mpim_row_type  rows[25] = '{
		'{8'h03, 16'h1388, 8'h4, 8'h0, 1'b0, 8'h0, 32'h0, 8'h0, 32'h1234},
		'{8'h04, 16'h1389, 8'h3, 8'h0, 1'b0, 8'h0, 32'h0, 8'h0, 32'hab00},
		'{8'h03, 16'h138a, 8'h2, 8'h1, 1'b0, 8'h0, 32'h0, 8'h0, 32'hdead},
		'{8'h03, 16'h138c, 8'h1, 8'h0, 1'b0, 8'h0, 32'h0, 8'h2, 32'h0},
		'{8'h10, 16'h1388, 8'h1, 8'h0, 1'b0, 8'h0, 32'h0, 8'h2, 32'h0},
		'{8'h06, 16'h1770, 8'h1, 8'h0, 1'b0, 8'h0, 32'h5555, 8'h0, 32'h0},
		'{8'h10, 16'h1771, 8'h1, 8'h0, 1'b0, 8'h0, 32'h7777, 8'h0, 32'h0},
		// combined function writing the receive image
		'{8'h17, 16'h1771, 8'h1, 8'h0, 1'b1, 8'h0, 32'h8888, 8'h0, 32'h0},
		'{8'h03, 16'h1770, 8'h1, 8'h0, 1'b0, 8'h0, 32'h0, 8'h2, 32'h0},
		'{8'h05, 16'h1388, 8'h1, 8'h0, 1'b0, 8'h0, 32'h0, 8'h1, 32'h0},
		'{8'h03, 16'h1388, 8'h0, 8'h0, 1'b0, 8'h0, 32'h0, 8'h3, 32'h0},
		'{8'h03, 16'h0000, 8'h1, 8'h0, 1'b0, 8'h0, 32'h0, 8'h2, 32'h0},
		'{8'h06, 16'h07d0, 8'h1, 8'h0, 1'b0, 8'h0, 32'h0, 8'h1, 32'h0},
		'{8'h03, 16'h07d0, 8'h2, 8'h0, 1'b0, 8'h0, 32'h0, 8'h0, 32'h1122},
		'{8'h17, 16'h07d0, 8'h2, 8'h1, 1'b0, 8'h0, 32'h0, 8'h0, 32'h3344},
		'{8'h10, 16'h07d0, 8'h2, 8'h0, 1'b0, 8'h0, 32'h0, 8'h2, 32'h0},
		'{8'h03, 16'h0bb8, 8'h2, 8'h0, 1'b0, 8'h0, 32'h0, 8'h2, 32'h0},
		'{8'h03, 16'h07d1, 8'h2, 8'h0, 1'b0, 8'h0, 32'h0, 8'h2, 32'h0},
		'{8'h10, 16'h0bba, 8'h1, 8'h0, 1'b0, 8'h0, 32'h0, 8'h3, 32'h0},
		'{8'h10, 16'h0bba, 8'h2, 8'h0, 1'b0, 8'h0, 32'hcafe, 8'h0, 32'h0},
		'{8'h10, 16'h0bba, 8'h2, 8'h1, 1'b0, 8'h0, 32'hf00d, 8'h0, 32'h0},
		'{8'h2b, 16'h3602, 8'h0, 8'h0, 1'b1, 8'h1, 32'h1, 8'h3, 32'h0},
		'{8'h2b, 16'h3602, 8'h0, 8'h0, 1'b1, 8'h0, 32'h11, 8'h3, 32'h0},
		'{8'h2b, 16'h3602, 8'h0, 8'h0, 1'b0, 8'h11, 32'h0, 8'h2, 32'h0},
		'{8'h2b, 16'h3502, 8'h0, 8'h0, 1'b0, 8'h2, 32'h0, 8'h0, 32'h60400010}};
	always #5 mclk = ~mclk;
	mpim_mapper mpim_mapper_inst (.mclk_i(mclk), .rst_n_i(rst_n), .req_i(req), .req_func_i(func),
		.req_addr_i(addr), .req_qty_i(qty), .req_beat_i(beat), .req_wr_i(wr), .req_sub_i(sub),
		.req_wdata_i(wdata), .rsp_valid_o(rsp_valid), .rsp_exc_o(rsp_exc), .rsp_rdata_o(rsp_rdata),
		.rx_sel_i(rx_sel), .rx_val_o(rx_val), .tx_we_i(tx_we), .tx_sel_i(tx_sel), .tx_val_i(tx_val),
		.upi_sel_i(upi_sel), .upi_val_o(upi_val), .upo_we_i(upo_we), .upo_sel_i(upo_sel),
		.upo_val_i(upo_val), .prog_loaded_i(loaded), .prog_fault_i(fault),
		.prog_fault_code_i(code), .prog_state_o(state), .prog_run_o(run), .prog_err_o(err));
	mpim_master mpim_master_inst (.mclk_i(mclk), .rsp_valid_i(rsp_valid), .rsp_exc_i(rsp_exc),
		.rsp_rdata_i(rsp_rdata), .req_o(req), .func_o(func), .addr_o(addr), .qty_o(qty),
		.beat_o(beat), .wr_o(wr), .sub_o(sub), .wdata_o(wdata));
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, rsp_valid}, 32'h0);
		chk({30'h0, state}, {30'h0, PS_STOP});
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, run}, 32'h1);
		mpim_master_inst.map(16'h3602, 4'h4, {32'h60640020, 32'h60610008, 32'h00050008,
			32'h60410010});
		mpim_master_inst.map(16'h3502, 4'h2, {64'h0, 32'h60400010, 32'h00030010});
		// device side fills transmit fields and output word
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			tx_we  <= 1'b1;
			tx_sel <= 4'(i);
			tx_val <= tv[i];
		end
		@(posedge mclk);
		tx_we   <= 1'b0;
		upo_we  <= 1'b1;
		upo_val <= 32'h11223344;
		@(posedge mclk);
		upo_we <= 1'b0;
		foreach (rows[i]) begin
			mpim_master_inst.beat(rows[i].f, rows[i].a, {8'h0, rows[i].q}, {8'h0, rows[i].b},
				rows[i].w, rows[i].s, rows[i].d, e, r);
			chk({24'h0, e}, {24'h0, rows[i].e});
			chk(r, rows[i].r);
		end
		@(posedge mclk);
		upi_sel <= 5'h1;
		@(posedge mclk);
		#1;
		chk(rx_val, 32'h0);
		chk(upi_val, 32'hcafef00d);
		@(posedge mclk);
		rx_sel <= 4'h1;
		@(posedge mclk);
		#1;
		chk(rx_val, 32'h8888);
		@(posedge mclk);
		fault <= 1'b1;
		code  <= 8'h05;
		@(posedge mclk);
		fault <= 1'b0;
		#1;
		chk({30'h0, state}, {30'h0, PS_FAULT});
		chk({24'h0, err}, 32'h5);
		mpim_master_inst.beat(8'h2b, 16'h2302, 16'h0, 16'h0, 1'b0, 8'h0, 32'h0, e, r);
		chk(r, 32'h5);
		mpim_master_inst.beat(8'h2b, 16'h2300, 16'h0, 16'h0, 1'b1, 8'h0, 32'h0, e, r);
		@(posedge mclk);
		#1;
		chk({30'h0, state}, {30'h0, PS_STOP});
		// mid-run reset with no program present: no autostart
		@(posedge mclk);
		loaded <= 1'b0;
		rst_n  <= 1'b0;
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, run}, 32'h0);
		chk({31'h0, rsp_valid}, 32'h0);
		chk({24'h0, err}, 32'h0);
		mpim_master_inst.beat(8'h2b, 16'h3602, 16'h0, 16'h0, 1'b0, 8'h0, 32'h0, e, r);
		chk({24'h0, e}, 32'h0);
		chk(r, 32'h0);
		// program appears later and starts by itself
		@(posedge mclk);
		loaded <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk({31'h0, run}, 32'h1);
		tally_and_finish();
	end
endmodule : testbench
bind mpim_mapper mpim_chk mpim_chk_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i),
	.req_func_i(req_func_i), .req_addr_i(req_addr_i), .req_qty_i(req_qty_i),
	.rsp_valid_o(rsp_valid_o), .rsp_exc_o(rsp_exc_o), .rsp_rdata_o(rsp_rdata_o),
	.prog_fault_i(prog_fault_i), .prog_fault_code_i(prog_fault_code_i),
	.prog_state_o(prog_state_o), .prog_run_o(prog_run_o), .prog_err_o(prog_err_o));
`default_nettype wire
